// file: design/accel_sample_buffer_control.sv
// acceleration sample buffer control with avalon-mm register slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module accel_sample_buffer_control
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_data_i,
    input wire accel_buffer_pkg::trig_events_type trig_events_i,
    input wire logic sleep_state_i,
    input wire logic [7:0] sleep_delay_count_i
);

    // ----------------------------------------
    // state and helpers
    // ----------------------------------------
    accel_buffer_pkg::state_type s_q;
    accel_buffer_pkg::state_type s_d;

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = p + 5'h01;
    endfunction

    function automatic logic [4:0] ptr_dec(input logic [4:0] p);
        ptr_dec = p - 5'h01;
    endfunction

    logic [5:0] idx;
    logic req;
    logic [15:0] fifo_head;
    logic [15:0] lifo_head;
    logic [5:0] post_limit;
    logic wmrk_flag;
    assign idx = avs_address_i[7:2];
    assign req = avs_read_i | avs_write_i;
    assign fifo_head = s_q.mem[s_q.rd];
    assign lifo_head = s_q.mem[ptr_dec(s_q.wr)];
    // watermark flag derives from count so a disable clears it with the count
    assign wmrk_flag = (s_q.watermark_count != 6'h00) && (s_q.cnt >= s_q.watermark_count);
    // a watermark of 32 or more leaves no room after the trigger
    assign post_limit = (s_q.watermark_count >= accel_buffer_pkg::DEPTH_CNT) ? 6'h00 :
        accel_buffer_pkg::DEPTH_CNT - s_q.watermark_count;

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    // one wait cycle: data is latched in the first cycle, answered in the second
    assign avs_waitrequest_o = req & ~s_q.ack;
    assign avs_readdata_o = s_q.rdata;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb
    begin
        logic flush;
        logic emptied;
        logic push;
        logic drop_old;
        logic eff_gate;
        logic trig_hit;
        logic [1:0] mode_n;
        flush = 1'b0;
        emptied = 1'b0;
        push = 1'b0;
        drop_old = 1'b0;
        eff_gate = 1'b0;
        trig_hit = 1'b0;
        mode_n = 2'b00;
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        s_d.last_sleep = sleep_state_i;

        // register writes take effect at the answering edge
        if (avs_write_i && s_q.ack)
        begin
            if (idx == accel_buffer_pkg::IDX_SETUP_ONE)
            begin
                if (!s_q.active && !s_q.pin_two_function_select)
                begin
                    s_d.setup_one = avs_writedata_i[7:0];
                    if (avs_writedata_i[accel_buffer_pkg::MODE_HI:accel_buffer_pkg::MODE_LO]
                        == accel_buffer_pkg::MODE_OFF)
                    begin
                        flush = 1'b1;
                    end
                end
            end
            else if (idx == accel_buffer_pkg::IDX_SETUP_TWO)
            begin
                s_d.watermark_count = avs_writedata_i[5:0];
                flush = avs_writedata_i[accel_buffer_pkg::FLUSH_BIT];
            end
            else if (idx == accel_buffer_pkg::IDX_SENSOR)
            begin
                s_d.active = avs_writedata_i[accel_buffer_pkg::ACTIVE_BIT];
                s_d.pin_two_function_select = avs_writedata_i[accel_buffer_pkg::PIN_TWO_BIT];
                s_d.ext_trig = avs_writedata_i[accel_buffer_pkg::EXT_TRIG_BIT];
                // leaving standby starts from an empty buffer
                if (!s_q.active && !s_q.ext_trig && (s_d.active || s_d.ext_trig))
                begin
                    flush = 1'b1;
                end
            end
        end

        // read data latched in the first cycle; a sample pop happens here once
        if (avs_read_i && !s_q.ack)
        begin
            s_d.rdata = 32'h0000_0000;
            unique case (idx)
                accel_buffer_pkg::IDX_SETUP_ONE: s_d.rdata[7:0] = s_q.setup_one;
                accel_buffer_pkg::IDX_SETUP_TWO: s_d.rdata[5:0] = s_q.watermark_count;
                accel_buffer_pkg::IDX_STATUS:
                begin
                    s_d.rdata[5:0] = s_q.cnt;
                    s_d.rdata[accel_buffer_pkg::OVF_BIT] = s_q.overflow_flag;
                    s_d.rdata[accel_buffer_pkg::WMRK_FLAG_BIT] = wmrk_flag;
                    s_d.rdata[accel_buffer_pkg::TRIGD_BIT] = s_q.triggered;
                end
                accel_buffer_pkg::IDX_GATE:
                begin
                    s_d.rdata[7:0] = s_q.drop_cnt;
                    s_d.rdata[accel_buffer_pkg::DROP_BIT] = s_q.drop;
                end
                accel_buffer_pkg::IDX_SENSOR:
                begin
                    s_d.rdata[accel_buffer_pkg::ACTIVE_BIT] = s_q.active;
                    s_d.rdata[accel_buffer_pkg::PIN_TWO_BIT] = s_q.pin_two_function_select;
                    s_d.rdata[accel_buffer_pkg::EXT_TRIG_BIT] = s_q.ext_trig;
                end
                accel_buffer_pkg::IDX_SAMPLE:
                begin
                    if (s_q.cnt != 6'h00)
                    begin
                        if (s_q.setup_one[accel_buffer_pkg::ORDER_BIT])
                        begin
                            s_d.rdata[15:0] = lifo_head;
                            s_d.wr = ptr_dec(s_q.wr);
                        end
                        else
                        begin
                            s_d.rdata[15:0] = fifo_head;
                            s_d.rd = ptr_inc(s_q.rd);
                        end
                        s_d.cnt = s_q.cnt - 6'h01;
                        emptied = (s_q.cnt == 6'h01);
                    end
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        mode_n = s_d.setup_one[accel_buffer_pkg::MODE_HI:accel_buffer_pkg::MODE_LO];
        // triggered mode with auto-sleep running overrides the hold bit
        eff_gate = s_d.setup_one[accel_buffer_pkg::GATE_BIT] &&
            !((mode_n == accel_buffer_pkg::MODE_TRIG) && (sleep_delay_count_i != 8'h00));

        // wake/sleep transition: hold or flush so two rates never mix
        if (sleep_state_i != s_q.last_sleep)
        begin
            if (eff_gate && (s_d.cnt != 6'h00))
            begin
                s_d.hold = 1'b1;
            end
            else
            begin
                flush = 1'b1;
            end
        end

        // flush or full read-out releases everything tied to the old contents
        if (flush || emptied)
        begin
            s_d.overflow_flag = 1'b0;
            s_d.triggered = 1'b0;
            s_d.post = 6'h00;
            s_d.hold = 1'b0;
            s_d.drop = 1'b0;
            s_d.drop_cnt = 8'h00;
        end
        if (flush)
        begin
            s_d.cnt = 6'h00;
            s_d.wr = 5'h00;
            s_d.rd = 5'h00;
        end

        // trigger arms once per collection; later events are ignored
        trig_hit = (s_d.setup_one[accel_buffer_pkg::WITHIN_BIT] && trig_events_i.within_threshold)
            || (s_d.setup_one[accel_buffer_pkg::OUTSIDE_BIT] && trig_events_i.outside_threshold)
            || (s_d.setup_one[accel_buffer_pkg::ORIENT_BIT] && trig_events_i.orientation);
        if ((mode_n == accel_buffer_pkg::MODE_TRIG) && trig_hit && !s_d.triggered
            && !s_d.overflow_flag)
        begin
            s_d.triggered = 1'b1;
            s_d.post = 6'h00;
            s_d.overflow_flag = (post_limit == 6'h00);
        end

        // sample intake; flush above already happened, so it lands at the new rate
        if (sample_valid_i && (mode_n != accel_buffer_pkg::MODE_OFF))
        begin
            if (s_d.hold)
            begin
                s_d.drop = 1'b1;
                if (s_d.drop_cnt != 8'hff)
                begin
                    s_d.drop_cnt = s_d.drop_cnt + 8'h01;
                end
            end
            else
            begin
                unique case (mode_n)
                    accel_buffer_pkg::MODE_STREAM:
                    begin
                        push = 1'b1;
                        drop_old = (s_d.cnt == accel_buffer_pkg::DEPTH_CNT);
                        if (drop_old)
                        begin
                            s_d.overflow_flag = 1'b1;
                        end
                    end
                    accel_buffer_pkg::MODE_STOP:
                    begin
                        push = (s_d.cnt != accel_buffer_pkg::DEPTH_CNT);
                        if (!push)
                        begin
                            s_d.overflow_flag = 1'b1;
                        end
                    end
                    accel_buffer_pkg::MODE_TRIG:
                    begin
                        if (!s_d.triggered)
                        begin
                            // circular pre-trigger window of watermark depth
                            push = (s_d.cnt < s_d.watermark_count) || (s_d.cnt != 6'h00);
                            drop_old = (s_d.cnt >= s_d.watermark_count) && (s_d.cnt != 6'h00);
                        end
                        else if (!s_d.overflow_flag && (s_d.post < post_limit)
                            && (s_d.cnt != accel_buffer_pkg::DEPTH_CNT))
                        begin
                            push = 1'b1;
                            s_d.post = s_d.post + 6'h01;
                            s_d.overflow_flag = (s_d.post == post_limit);
                        end
                    end
                    default: push = 1'b0;
                endcase
            end
        end

        if (push)
        begin
            s_d.mem[s_d.wr] = sample_data_i;
            s_d.wr = ptr_inc(s_d.wr);
            if (drop_old)
            begin
                s_d.rd = ptr_inc(s_d.rd);
            end
            else
            begin
                s_d.cnt = s_d.cnt + 6'h01;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
            s_q.setup_one <= accel_buffer_pkg::SETUP_ONE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [1:0] mode_q;
    assign mode_q = s_q.setup_one[accel_buffer_pkg::MODE_HI:accel_buffer_pkg::MODE_LO];

    sequence sample_read_s;
        avs_read_i && !s_q.ack && (idx == accel_buffer_pkg::IDX_SAMPLE) && (s_q.cnt != 6'h00);
    endsequence

    sequence locked_write_s;
        avs_write_i && s_q.ack && (idx == accel_buffer_pkg::IDX_SETUP_ONE)
            && (s_q.active || s_q.pin_two_function_select);
    endsequence

    fifo_order_a: assert property (sample_read_s ##0 !s_q.setup_one[accel_buffer_pkg::ORDER_BIT]
        |=> s_q.rdata[15:0] == $past(fifo_head)) else $error("oldest-first order broken");
    lifo_order_a: assert property (sample_read_s ##0 s_q.setup_one[accel_buffer_pkg::ORDER_BIT]
        |=> s_q.rdata[15:0] == $past(lifo_head)) else $error("newest-first order broken");
    config_lock_a: assert property (locked_write_s |=> $stable(s_q.setup_one))
        else $error("setup changed while locked");
    disabled_empty_a: assert property (mode_q == accel_buffer_pkg::MODE_OFF |-> s_q.cnt == 6'h00)
        else $error("disabled buffer holds samples");
    stream_wrap_a: assert property ((mode_q == accel_buffer_pkg::MODE_STREAM) && sample_valid_i
        && !s_q.hold && !req && (s_q.cnt == accel_buffer_pkg::DEPTH_CNT)
        && (sleep_state_i == s_q.last_sleep)
        |=> (s_q.cnt == accel_buffer_pkg::DEPTH_CNT) && s_q.overflow_flag)
        else $error("stream overwrite failed");
    stop_full_a: assert property ((mode_q == accel_buffer_pkg::MODE_STOP) && !req
        && (s_q.cnt == accel_buffer_pkg::DEPTH_CNT) && (sleep_state_i == s_q.last_sleep)
        |=> $stable(s_q.wr) && $stable(s_q.rd)) else $error("stop mode took a sample");
    post_limit_a: assert property (s_q.triggered |-> s_q.post <= post_limit)
        else $error("post-trigger count overrun");
    drop_count_a: assert property (s_q.hold && sample_valid_i && !req
        && (mode_q != accel_buffer_pkg::MODE_OFF) && (s_q.drop_cnt != 8'hff)
        && (sleep_state_i == s_q.last_sleep)
        |=> s_q.drop && (s_q.drop_cnt == $past(s_q.drop_cnt) + 8'h01))
        else $error("discard not counted");
    empty_rearm_a: assert property (sample_read_s ##0 (s_q.cnt == 6'h01)
        |=> !s_q.overflow_flag && !s_q.triggered && !s_q.hold && !s_q.drop)
        else $error("read-out did not re-arm");

endmodule // accel_sample_buffer_control

// file: design/accel_buffer_pkg.sv
// constants and types for the acceleration sample buffer control
package accel_buffer_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SETUP_ONE = 6'h26;
    localparam logic [5:0] IDX_SETUP_TWO = 6'h27;
    localparam logic [5:0] IDX_STATUS = 6'h28;
    localparam logic [5:0] IDX_SAMPLE = 6'h29;
    localparam logic [5:0] IDX_GATE = 6'h2a;
    localparam logic [5:0] IDX_SENSOR = 6'h2b;
    localparam logic [7:0] SETUP_ONE_RESET = 8'h00;
    // buffer_setup_one field positions
    localparam int ORDER_BIT = 7;
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 5;
    localparam int GATE_BIT = 4;
    localparam int WITHIN_BIT = 3;
    localparam int OUTSIDE_BIT = 2;
    localparam int ORIENT_BIT = 0;
    // buffer_setup_two and sensor control fields
    localparam int FLUSH_BIT = 7;
    localparam int ACTIVE_BIT = 0;
    localparam int PIN_TWO_BIT = 1;
    localparam int EXT_TRIG_BIT = 2;
    // status and gate field positions
    localparam int OVF_BIT = 6;
    localparam int WMRK_FLAG_BIT = 7;
    localparam int TRIGD_BIT = 8;
    localparam int DROP_BIT = 8;
    localparam int DEPTH = 32;
    localparam logic [5:0] DEPTH_CNT = 6'h20;
    localparam int SAMPLE_W = 16;
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_STREAM = 2'b01,
        MODE_STOP = 2'b10,
        MODE_TRIG = 2'b11
    } mode_type;
    typedef struct packed {
        logic within_threshold;
        logic outside_threshold;
        logic orientation;
    } trig_events_type;
    typedef struct packed {
        logic [DEPTH-1:0][SAMPLE_W-1:0] mem;
        logic [7:0] setup_one;
        logic [5:0] watermark_count;
        logic active;
        logic pin_two_function_select;
        logic ext_trig;
        logic [4:0] wr;
        logic [4:0] rd;
        logic [5:0] cnt;
        logic overflow_flag;
        logic triggered;
        logic [5:0] post;
        logic hold;
        logic drop;
        logic [7:0] drop_cnt;
        logic last_sleep;
        logic ack;
        logic [31:0] rdata;
    } state_type;
endpackage

// file: sim/sample_source.sv
// sample and event source model standing in for the sensing front end
`timescale 1ns/1ps
module sample_source
(
    input wire logic core_clk_i,
    output logic sample_valid_o,
    output logic [15:0] sample_data_o,
    output accel_buffer_pkg::trig_events_type trig_events_o,
    output logic sleep_state_o,
    output logic [7:0] sleep_delay_count_o
);
    // quiet front end at time zero
    initial
    begin
        sample_valid_o = 1'b0;
        sample_data_o = 16'h0000;
        trig_events_o = '0;
        sleep_state_o = 1'b0;
        sleep_delay_count_o = 8'h00;
    end

    // one sample per cycle; data shows the inverse of the last sample after the burst so stale data never matches
    task automatic push(input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk_i);
            sample_valid_o <= 1'b1;
            sample_data_o <= base + 16'(i);
        end
        @(posedge core_clk_i);
        sample_valid_o <= 1'b0;
        sample_data_o <= ~(base + 16'(n - 1));
    endtask

    // one-cycle event pulse, bit order within, outside, orientation
    task automatic fire(input logic [2:0] ev);
        @(posedge core_clk_i);
        trig_events_o <= ev;
        @(posedge core_clk_i);
        trig_events_o <= '0;
    endtask

    // one wake/sleep transition
    task automatic flip();
        @(posedge core_clk_i);
        sleep_state_o <= ~sleep_state_o;
    endtask

    // auto-sleep delay level
    task automatic set_delay(input logic [7:0] v);
        @(posedge core_clk_i);
        sleep_delay_count_o <= v;
    endtask
endmodule // sample_source

// file: sim/accel_sample_buffer_control_test.sv
// self-checking bench for the sample buffer control
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        end \
    end
module accel_sample_buffer_control_test;
    localparam logic [7:0] A1 = {accel_buffer_pkg::IDX_SETUP_ONE, 2'b00};
    localparam logic [7:0] A2 = {accel_buffer_pkg::IDX_SETUP_TWO, 2'b00};
    localparam logic [7:0] AS = {accel_buffer_pkg::IDX_STATUS, 2'b00};
    localparam logic [7:0] AD = {accel_buffer_pkg::IDX_SAMPLE, 2'b00};
    localparam logic [7:0] AG = {accel_buffer_pkg::IDX_GATE, 2'b00};
    localparam logic [7:0] AC = {accel_buffer_pkg::IDX_SENSOR, 2'b00};
    logic core_clk;
    logic reset_n;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [31:0] rdata;
    logic sample_valid;
    logic [15:0] sample_data;
    accel_buffer_pkg::trig_events_type trig_events;
    logic sleep_state;
    logic [7:0] sleep_delay;
    int fail_count = 0;
    int checks = 0;

    accel_sample_buffer_control accel_sample_buffer_control_i (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata),
        .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest),
        .sample_valid_i(sample_valid), .sample_data_i(sample_data),
        .trig_events_i(trig_events), .sleep_state_i(sleep_state),
        .sleep_delay_count_i(sleep_delay));
    sample_source sample_source_i (
        .core_clk_i(core_clk), .sample_valid_o(sample_valid), .sample_data_o(sample_data),
        .trig_events_o(trig_events), .sleep_state_o(sleep_state),
        .sleep_delay_count_o(sleep_delay));

    // 40 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // bus tasks and verdict
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge; data taken at that edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        read <= ~w;
        write <= w;
        writedata <= d;
        @(posedge core_clk);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    // masked read compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        bus(a, 1'b0, 32'h0);
        `CHK(nm, e, rdata & m)
    endtask

    // hang guard well inside the cycle budget
    initial
    begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rdc(A1, 32'hff, 32'h0, "setup_one reset");
        wr(8'h00, 32'hff);
        rdc(8'h00, 32'hffffffff, 32'h0, "unmapped");
        src_i_dummy();
        report_and_stop();
    end
    task automatic src_i_dummy();
        logic [7:0] en;
        logic [2:0] ev;
        sample_source_i.push(16'h0100, 3);
        rdc(AS, 32'h3f, 32'h0, "count off");
        // stop mode: fill past full, oldest first
        wr(A1, 32'h40);
        sample_source_i.push(16'h0001, 33);
        rdc(AS, 32'h7f, 32'h60, "stop full");
        rdc(AD, 32'hffff, 32'h1, "fifo first");
        rdc(AD, 32'hffff, 32'h2, "fifo second");
        wr(A1, 32'h00);
        rdc(AS, 32'hff, 32'h0, "status off");
        // stream mode keeps the newest entries
        wr(A1, 32'h20);
        sample_source_i.push(16'h0001, 34);
        rdc(AD, 32'hffff, 32'h3, "stream oldest");
        wr(A1, 32'h00);
        wr(A1, 32'ha0);
        sample_source_i.push(16'h0001, 34);
        rdc(AD, 32'hffff, 32'h22, "lifo first");
        rdc(AD, 32'hffff, 32'h21, "lifo second");
        // entering active or external trigger flushes; setup locked while active or pin two is set
        wr(AC, 32'h01);
        rdc(AS, 32'h3f, 32'h0, "active flush");
        wr(A1, 32'h40);
        rdc(A1, 32'hff, 32'ha0, "locked active");
        wr(AC, 32'h02);
        wr(A1, 32'h40);
        rdc(A1, 32'hff, 32'ha0, "locked pin two");
        wr(AC, 32'h00);
        sample_source_i.push(16'h0001, 2);
        wr(AC, 32'h04);
        rdc(AS, 32'h3f, 32'h0, "ext flush");
        wr(AC, 32'h00);
        // triggered mode, each source on its own, the two disabled ones pulsed first
        for (int s = 0; s < 3; s++)
        begin
            en = (s == 0) ? 8'h08 : (s == 1) ? 8'h04 : 8'h01;
            ev = (s == 0) ? 3'b100 : (s == 1) ? 3'b010 : 3'b001;
            wr(A1, 32'h00);
            wr(A2, 32'h04);
            wr(A1, {24'h0, 8'h60 | en});
            sample_source_i.push(16'h0010, 6);
            rdc(AS, 32'h3f, 32'h4, "pre count");
            sample_source_i.fire(~ev);
            sample_source_i.push(16'h0020, 1);
            rdc(AS, 32'h3f, 32'h4, "masked trig");
            sample_source_i.fire(ev);
            sample_source_i.push(16'h0030, 30);
            rdc(AS, 32'h7f, 32'h60, "post full");
        end
        rdc(AD, 32'hffff, 32'h13, "pre oldest");
        repeat (31) bus(AD, 1'b0, 32'h0);
        rdc(AS, 32'h7f, 32'h0, "readout clears");
        sample_source_i.push(16'h0010, 6);
        rdc(AS, 32'h3f, 32'h4, "rearmed");
        sample_source_i.fire(3'b001);
        sample_source_i.push(16'h0030, 30);
        wr(A2, 32'h84);
        rdc(AS, 32'h7f, 32'h0, "flush clears");
        // hold across a transition, then drop and count
        wr(A1, 32'h00);
        wr(A1, 32'h30);
        sample_source_i.push(16'h0040, 3);
        sample_source_i.flip();
        sample_source_i.push(16'h0050, 2);
        rdc(AS, 32'h3f, 32'h3, "held count");
        rdc(AG, 32'h1ff, 32'h102, "drop");
        rdc(AD, 32'hffff, 32'h40, "held data");
        rdc(AG, 32'h1ff, 32'h102, "drop stays");
        repeat (2) bus(AD, 1'b0, 32'h0);
        rdc(AG, 32'h1ff, 32'h0, "drop clear");
        sample_source_i.push(16'h0060, 1);
        rdc(AS, 32'h3f, 32'h1, "resume");
        // no hold: transition flushes
        wr(A1, 32'h00);
        wr(A1, 32'h20);
        sample_source_i.push(16'h0070, 3);
        sample_source_i.flip();
        rdc(AS, 32'h3f, 32'h0, "auto flush");
        // triggered mode with sleep delay ignores the hold bit
        wr(A1, 32'h00);
        wr(A1, 32'h78);
        sample_source_i.set_delay(8'h05);
        sample_source_i.push(16'h0080, 3);
        sample_source_i.flip();
        rdc(AS, 32'h3f, 32'h0, "hold ignored");
        sample_source_i.push(16'h0090, 1);
        rdc(AS, 32'h3f, 32'h1, "no gate");
    endtask
endmodule // accel_sample_buffer_control_test
